// ### design/rpm_power_mgr.sv
// rpm_power_mgr: per-lane power state control of a four-lane redriver,
// plus strap decode of equalizer and flat gain settings per lane.
// assumes the analog front end supplies a per-lane signal detector level
// and a receiver detection handshake (request pulse out, done/load back),
// all synchronous to ref_clk_in.
//
// Behaviour
// - idle input moves active lane into slumber
// - each lane decides slumber entry on its own
// - signal detector stays on during slumber
// - entering slumber starts a receiver detection
// - no load gives unplug, detection repeats
// - load found in unplug returns to slumber
// - slumber repeats detection every 6 ms
// - one enable per lane pair, high enables
// - equalizer strap decodes to four settings, open default
// - gain strap decodes to four settings, open default
// - disabled pair holds both lanes powered off
`timescale 1ns/10ps
module rpm_power_mgr
	import rpm_pkg::*;
#(
	parameter int DET_PERIOD = DET_PERIOD_CYC
)
(
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       first_pair_enable_in,
	input  wire logic       second_pair_enable_in,
	input  wire logic [3:0] sig_active_in,
	input  wire logic [3:0] det_done_in,
	input  wire logic [3:0] det_load_in,
	input  wire logic [1:0] equalizer_strap_lane_a_in,
	input  wire logic [1:0] equalizer_strap_lane_b_in,
	input  wire logic [1:0] equalizer_strap_lane_c_in,
	input  wire logic [1:0] equalizer_strap_lane_d_in,
	input  wire logic [1:0] gain_strap_lane_a_in,
	input  wire logic [1:0] gain_strap_lane_b_in,
	input  wire logic [1:0] gain_strap_lane_c_in,
	input  wire logic [1:0] gain_strap_lane_d_in,
	output logic      [3:0] det_req_out,
	output logic      [3:0] sigdet_en_out,
	output logic      [3:0] powered_off_state_out,
	output logic      [3:0] active_state_out,
	output logic      [3:0] slumber_state_out,
	output logic      [3:0] unplug_state_out,
	output logic      [3:0] eq_setting_lane_a_out,
	output logic      [3:0] eq_setting_lane_b_out,
	output logic      [3:0] eq_setting_lane_c_out,
	output logic      [3:0] eq_setting_lane_d_out,
	output logic      [3:0] gain_setting_lane_a_out,
	output logic      [3:0] gain_setting_lane_b_out,
	output logic      [3:0] gain_setting_lane_c_out,
	output logic      [3:0] gain_setting_lane_d_out
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed
	{
		rpm_state_e [3:0]            st;
		logic       [3:0][3:0]       mode;
		logic       [3:0][TMR_W-1:0] tmr;
		logic       [3:0]            det_req;
		logic       [3:0]            sigdet_en;
	} rpm_lanes_s;

	rpm_lanes_s lanes_q;
	rpm_lanes_s lanes_d;

	logic [1:0] pair_en;
	logic [TMR_W-1:0] tmr_reload;

	// lanes a,b share the first enable; c,d the second
	assign pair_en    = {second_pair_enable_in, first_pair_enable_in};
	assign tmr_reload = TMR_W'(DET_PERIOD - 1);

	function automatic logic [3:0] rpm_state_mode(input rpm_state_e st);
		logic [3:0] mode;
		mode = MODE_OFF;
		case (st)
			ST_OFF:     mode = MODE_OFF;
			ST_ACTIVE:  mode = MODE_ACTIVE;
			ST_SLUMBER: mode = MODE_SLUMBER;
			ST_UNPLUG:  mode = MODE_UNPLUG;
			ST_DET_S:   mode = MODE_SLUMBER;
			ST_DET_U:   mode = MODE_UNPLUG;
			default:    mode = MODE_OFF;
		endcase
		return mode;
	endfunction : rpm_state_mode

	////////////////////////////////////////////////////////////////////////
	// per-lane state machines, each lane fully independent

	always_comb
	begin
		lanes_d = lanes_q;
		for (int i = 0; i < NUM_LANES; i++)
		begin
			lanes_d.det_req[i] = 1'b0;
			if (!pair_en[i / 2])
			begin
				// enable low overrides every detector report
				lanes_d.st[i]  = ST_OFF;
				lanes_d.tmr[i] = '0;
			end
			else
			begin
				case (lanes_q.st[i])
					ST_OFF:
					begin
						// first move after enable is always a detection
						lanes_d.st[i]      = ST_DET_S;
						lanes_d.det_req[i] = 1'b1;
					end
					ST_ACTIVE:
					begin
						if (!sig_active_in[i])
						begin
							// slumber is entered through a detection
							lanes_d.st[i]      = ST_DET_S;
							lanes_d.det_req[i] = 1'b1;
						end
					end
					ST_SLUMBER:
					begin
						if (sig_active_in[i])
						begin
							lanes_d.st[i] = ST_ACTIVE;
						end
						else if (lanes_q.tmr[i] == '0)
						begin
							lanes_d.st[i]      = ST_DET_S;
							lanes_d.det_req[i] = 1'b1;
						end
						else
						begin
							lanes_d.tmr[i] = lanes_q.tmr[i] - TMR_W'(1);
						end
					end
					ST_DET_S:
					begin
						if (det_done_in[i] && det_load_in[i])
						begin
							lanes_d.st[i]  = ST_SLUMBER;
							lanes_d.tmr[i] = tmr_reload;
						end
						else if (det_done_in[i])
						begin
							lanes_d.st[i] = ST_UNPLUG;
						end
					end
					ST_UNPLUG:
					begin
						// unplugged lanes probe back to back
						lanes_d.st[i]      = ST_DET_U;
						lanes_d.det_req[i] = 1'b1;
					end
					ST_DET_U:
					begin
						if (det_done_in[i] && det_load_in[i])
						begin
							lanes_d.st[i]  = ST_SLUMBER;
							lanes_d.tmr[i] = tmr_reload;
						end
						else if (det_done_in[i])
						begin
							lanes_d.st[i] = ST_UNPLUG;
						end
					end
					default:
					begin
						lanes_d.st[i] = ST_OFF;
					end
				endcase
			end
			lanes_d.mode[i] = rpm_state_mode(lanes_d.st[i]);
			// detector keeps watching in every powered state
			lanes_d.sigdet_en[i] = (lanes_d.st[i] != ST_OFF);
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			// per element, so no plain vector lands in the enum array
			for (int i = 0; i < NUM_LANES; i++)
			begin
				lanes_q.st[i] <= ST_OFF;
			end
			lanes_q.mode      <= {NUM_LANES{MODE_OFF}};
			lanes_q.tmr       <= '0;
			lanes_q.det_req   <= '0;
			lanes_q.sigdet_en <= '0;
		end
		else
		begin
			lanes_q <= lanes_d;
		end
	end

	always_comb
	begin
		for (int i = 0; i < NUM_LANES; i++)
		begin
			powered_off_state_out[i] = lanes_q.mode[i][0];
			active_state_out[i]      = lanes_q.mode[i][1];
			slumber_state_out[i]     = lanes_q.mode[i][2];
			unplug_state_out[i]      = lanes_q.mode[i][3];
		end
	end

	assign det_req_out   = lanes_q.det_req;
	assign sigdet_en_out = lanes_q.sigdet_en;

	////////////////////////////////////////////////////////////////////////
	// strap decode, one leaf per lane

	logic [3:0][1:0] eq_lvl;
	logic [3:0][1:0] gain_lvl;
	logic [3:0][3:0] eq_set;
	logic [3:0][3:0] gain_set;

	assign eq_lvl   = {equalizer_strap_lane_d_in, equalizer_strap_lane_c_in,
			   equalizer_strap_lane_b_in, equalizer_strap_lane_a_in};
	assign gain_lvl = {gain_strap_lane_d_in, gain_strap_lane_c_in,
			   gain_strap_lane_b_in, gain_strap_lane_a_in};

	for (genvar g = 0; g < NUM_LANES; g++)
	begin : g_strap
		rpm_strap_dec u_strap
		(
			.ref_clk_in       (ref_clk_in),
			.rst_n_in         (rst_n_in),
			.eq_level_in      (eq_lvl[g]),
			.gain_level_in    (gain_lvl[g]),
			.eq_setting_out   (eq_set[g]),
			.gain_setting_out (gain_set[g])
		);
	end

	assign eq_setting_lane_a_out   = eq_set[0];
	assign eq_setting_lane_b_out   = eq_set[1];
	assign eq_setting_lane_c_out   = eq_set[2];
	assign eq_setting_lane_d_out   = eq_set[3];
	assign gain_setting_lane_a_out = gain_set[0];
	assign gain_setting_lane_b_out = gain_set[1];
	assign gain_setting_lane_c_out = gain_set[2];
	assign gain_setting_lane_d_out = gain_set[3];

endmodule : rpm_power_mgr

// ### design/rpm_strap_dec.sv
// rpm_strap_dec: registers the decoded equalizer and flat-gain settings
// of one lane.
// assumes strap level codes are synchronous to ref_clk_in.
`timescale 1ns/10ps
module rpm_strap_dec
	import rpm_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [1:0] eq_level_in,
	input  wire logic [1:0] gain_level_in,
	output logic      [3:0] eq_setting_out,
	output logic      [3:0] gain_setting_out
);

	typedef struct packed
	{
		logic [3:0] eq;
		logic [3:0] gain;
	} rpm_strap_s;

	rpm_strap_s strap_q;
	rpm_strap_s strap_d;

	always_comb
	begin
		strap_d      = strap_q;
		strap_d.eq   = rpm_lvl_decode(eq_level_in);
		strap_d.gain = rpm_lvl_decode(gain_level_in);
	end

	// reset shows the open-pin default until the first sample lands
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			strap_q <= '{eq: SET_DEFAULT, gain: SET_DEFAULT};
		end
		else
		begin
			strap_q <= strap_d;
		end
	end

	assign eq_setting_out   = strap_q.eq;
	assign gain_setting_out = strap_q.gain;

endmodule : rpm_strap_dec

// ### shared/rpm_pkg.sv
// rpm_pkg: constants, state codes and the strap level decoder shared by
// the redriver channel power manager and its strap decode leaf.
// assumes a single 20 MHz reference clock and 2-bit strap level codes
// produced by the analog four-level comparators.
package rpm_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS  = 50;
	localparam int DET_PERIOD_NS  = 6000000;
	// detection repeat period in reference clock cycles (6 ms / 50 ns)
	localparam int DET_PERIOD_CYC = DET_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TMR_W          = 17;
	localparam int NUM_LANES      = 4;

	////////////////////////////////////////////////////////////////////////
	// four-level strap codes from the comparators
	localparam logic [1:0] LVL_LOW  = 2'h0;
	localparam logic [1:0] LVL_REXT = 2'h1;
	localparam logic [1:0] LVL_OPEN = 2'h2;
	localparam logic [1:0] LVL_HIGH = 2'h3;

	// decoded settings, one-hot: bit0 low, bit1 rext, bit2 open, bit3 high
	localparam logic [3:0] SET_LOW     = 4'h1;
	localparam logic [3:0] SET_REXT    = 4'h2;
	localparam logic [3:0] SET_OPEN    = 4'h4;
	localparam logic [3:0] SET_HIGH    = 4'h8;
	localparam logic [3:0] SET_DEFAULT = SET_OPEN;

	// analog meaning of each setting, tenths of a dB
	localparam int EQ5G_LOW_DB10   = 109;
	localparam int EQ5G_REXT_DB10  = 67;
	localparam int EQ5G_OPEN_DB10  = 89;
	localparam int EQ5G_HIGH_DB10  = 131;
	localparam int GAIN_LOW_DB10   = -30;
	localparam int GAIN_REXT_DB10  = -15;
	localparam int GAIN_OPEN_DB10  = 0;
	localparam int GAIN_HIGH_DB10  = 20;

	////////////////////////////////////////////////////////////////////////
	// channel states and reported power modes
	typedef enum logic [5:0]
	{
		ST_OFF     = 6'h01,
		ST_ACTIVE  = 6'h02,
		ST_SLUMBER = 6'h04,
		ST_UNPLUG  = 6'h08,
		ST_DET_S   = 6'h10,
		ST_DET_U   = 6'h20
	} rpm_state_e;

	localparam logic [3:0] MODE_OFF     = 4'h1;
	localparam logic [3:0] MODE_ACTIVE  = 4'h2;
	localparam logic [3:0] MODE_SLUMBER = 4'h4;
	localparam logic [3:0] MODE_UNPLUG  = 4'h8;

	function automatic logic [3:0] rpm_lvl_decode(input logic [1:0] lvl);
		logic [3:0] set;
		set = SET_DEFAULT;
		case (lvl)
			LVL_LOW:  set = SET_LOW;
			LVL_REXT: set = SET_REXT;
			LVL_OPEN: set = SET_OPEN;
			LVL_HIGH: set = SET_HIGH;
			default:  set = SET_DEFAULT;
		endcase
		return set;
	endfunction : rpm_lvl_decode

endpackage : rpm_pkg

// ### verification/rpm_det_model.sv
// rpm_det_model: far-side load detection answering each request.
// assumes one request at a time per lane; slow_in delays the answer.
`timescale 1ns/10ps
module rpm_det_model
(
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [3:0] det_req_in,
	input  wire logic [3:0] load_in,
	input  wire logic       slow_in,
	output logic      [3:0] det_done_out,
	output logic      [3:0] det_load_out
);
	logic [1:0] wait_q [4];
	always_ff @(posedge ref_clk_in)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (!rst_n_in)
				wait_q[i] <= 2'h0;
			else if (det_req_in[i])
				wait_q[i] <= slow_in ? 2'h3 : 2'h1;
			else if (wait_q[i] != 2'h0)
				wait_q[i] <= wait_q[i] - 2'h1;
		end
	end
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			det_done_out[i] = wait_q[i] == 2'h1;
	end
	// outside an answer the load line shows the inverse, never a stale match
	assign det_load_out = ~(det_done_out ^ load_in);
endmodule : rpm_det_model

// ### verification/rpm_power_mgr_assertions.sv
// rpm_power_mgr_assertions: lane power state checks at the top ports.
// assumes only the ports of rpm_power_mgr; one detection open per lane.
`timescale 1ns/10ps
module rpm_power_mgr_assertions
	import rpm_pkg::*;
#(
	parameter int DET_PERIOD = DET_PERIOD_CYC
)
(
	input wire logic       ref_clk_in,
	input wire logic       rst_n_in,
	input wire logic       first_pair_enable_in,
	input wire logic       second_pair_enable_in,
	input wire logic [3:0] sig_active_in,
	input wire logic [3:0] det_done_in,
	input wire logic [3:0] det_load_in,
	input wire logic [3:0] det_req_out,
	input wire logic [3:0] powered_off_state_out,
	input wire logic [3:0] active_state_out,
	input wire logic [3:0] slumber_state_out,
	input wire logic [3:0] unplug_state_out
);
	logic [3:0] en;
	logic [3:0] pend_q;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	assign en = {{2{second_pair_enable_in}}, {2{first_pair_enable_in}}};
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			pend_q <= 4'h0;
		else
			pend_q <= (pend_q & ~det_done_in | det_req_out) & en;
	end
	////////////////////////////////////////////////////////////////////////
	for (genvar i = 0; i < 4; i++)
	begin : g_lane
		int  idle_q;
		wire fin  = pend_q[i] & det_done_in[i] & en[i];
		wire calm = slumber_state_out[i] & ~pend_q[i] & ~det_req_out[i]
			& en[i];
		sequence s_reprobe;
			unplug_state_out[i] ##1 det_req_out[i];
		endsequence
		// quiet slumber cycles; any detection or activity restarts it
		always_ff @(posedge ref_clk_in)
		begin
			if (!rst_n_in || !calm || sig_active_in[i])
				idle_q <= 0;
			else
				idle_q <= idle_q + 1;
		end
		a_idle_detect: assert property (
			active_state_out[i] && !sig_active_in[i] && en[i]
			|=> det_req_out[i] && slumber_state_out[i])
			else $error("idle lane not probing");
		a_off_disabled: assert property (
			!en[i] |=> powered_off_state_out[i] && !det_req_out[i])
			else $error("disabled lane not off");
		a_enable_probe: assert property (
			powered_off_state_out[i] && en[i]
			|=> det_req_out[i] && slumber_state_out[i])
			else $error("enabled lane not probing");
		a_noload_unplug: assert property (
			fin && !det_load_in[i] |=> s_reprobe)
			else $error("no load but no unplug");
		a_load_slumber: assert property (
			fin && det_load_in[i]
			|=> slumber_state_out[i] && !det_req_out[i])
			else $error("load but no slumber");
		a_wake_active: assert property (
			calm && sig_active_in[i] |=> active_state_out[i])
			else $error("activity did not wake");
		a_period_due: assert property (
			idle_q == DET_PERIOD - 1 && calm && !sig_active_in[i]
			|=> det_req_out[i])
			else $error("periodic probe missing");
		a_period_early: assert property (
			idle_q > 0 && idle_q < DET_PERIOD |-> !det_req_out[i])
			else $error("periodic probe early");
	end
endmodule : rpm_power_mgr_assertions

bind rpm_power_mgr rpm_power_mgr_assertions #(.DET_PERIOD(DET_PERIOD)) u_chk
(
	.ref_clk_in            (ref_clk_in),
	.rst_n_in              (rst_n_in),
	.first_pair_enable_in  (first_pair_enable_in),
	.second_pair_enable_in (second_pair_enable_in),
	.sig_active_in         (sig_active_in),
	.det_done_in           (det_done_in),
	.det_load_in           (det_load_in),
	.det_req_out           (det_req_out),
	.powered_off_state_out (powered_off_state_out),
	.active_state_out      (active_state_out),
	.slumber_state_out     (slumber_state_out),
	.unplug_state_out      (unplug_state_out)
);

// ### verification/tb_rpm_power_mgr.sv
// tb_rpm_power_mgr: self-checking bench of the lane power manager.
// assumes rpm_det_model answers probes; period shortened to DP cycles.
`timescale 1ns/10ps
module tb_rpm_power_mgr;
	localparam int DP = 20;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       first_pair_enable = 1'b0;
	logic       second_pair_enable = 1'b0;
	logic       slow = 1'b0;
	logic [3:0] sig = 4'h0;
	logic [3:0] load = 4'h0;
	logic [1:0] lvl = 2'h0;
	logic [3:0] req, sden, off, act, slp, unp, done, ldo;
	logic [3:0] eq [4];
	logic [3:0] gn [4];
	logic [5:0] rows [4] = '{6'h01, 6'h12, 6'h24, 6'h38};
	int         err_count = 0;
	int         total_checks = 0;
	int         cyc_n = 0;
	int         n;
	always #25 clk = ~clk;
	rpm_det_model u_far
	(
		.ref_clk_in(clk), .rst_n_in(rst_n), .det_req_in(req),
		.load_in(load), .slow_in(slow), .det_done_out(done),
		.det_load_out(ldo)
	);
	rpm_power_mgr #(.DET_PERIOD(DP)) dut
	(
		.ref_clk_in(clk), .rst_n_in(rst_n),
		.first_pair_enable_in(first_pair_enable), .second_pair_enable_in(second_pair_enable),
		.sig_active_in(sig), .det_done_in(done), .det_load_in(ldo),
		.equalizer_strap_lane_a_in(lvl), .equalizer_strap_lane_b_in(lvl),
		.equalizer_strap_lane_c_in(lvl), .equalizer_strap_lane_d_in(lvl),
		.gain_strap_lane_a_in(lvl), .gain_strap_lane_b_in(lvl),
		.gain_strap_lane_c_in(lvl), .gain_strap_lane_d_in(lvl),
		.det_req_out(req), .sigdet_en_out(sden),
		.powered_off_state_out(off), .active_state_out(act),
		.slumber_state_out(slp), .unplug_state_out(unp),
		.eq_setting_lane_a_out(eq[0]), .eq_setting_lane_b_out(eq[1]),
		.eq_setting_lane_c_out(eq[2]), .eq_setting_lane_d_out(eq[3]),
		.gain_setting_lane_a_out(gn[0]), .gain_setting_lane_b_out(gn[1]),
		.gain_setting_lane_c_out(gn[2]), .gain_setting_lane_d_out(gn[3])
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic step(input int k);
		repeat (k) @(negedge clk);
	endtask : step
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	always @(posedge clk)
	begin
		cyc_n++;
		if (cyc_n == 3000)
		begin
			err_count++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		step(2);
		rst_n = 1'b1;
		sig = 4'hf;
		foreach (rows[r])
		begin
			lvl = rows[r][5:4];
			step(2);
			chk({eq[0], eq[1], eq[2], eq[3], gn[0], gn[1], gn[2], gn[3]},
				{8{rows[r][3:0]}});
		end
		chk({off, act, sden}, {4'hf, 4'h0, 4'h0});
		// lanes a and c see a load, b and d do not
		sig = 4'h0;
		load = 4'h5;
		first_pair_enable = 1'b1;
		second_pair_enable = 1'b1;
		step(4);
		chk({slp, unp, sden}, {4'h5, 4'ha, 4'hf});
		load = 4'hf;
		step(5);
		chk({slp, unp}, {4'hf, 4'h0});
		sig = 4'h1;
		step(2);
		chk({act, slp}, {4'h1, 4'he});
		sig = 4'h0;
		slow = 1'b1;
		step(1);
		chk({req[0], slp[0], act[0]}, 3'h6);
		n = 0;
		do
		begin
			step(1);
			n++;
		end
		while (req[0] !== 1'b1 && n < 100);
		chk(n, DP + 4);
		first_pair_enable = 1'b0;
		sig = 4'h3;
		step(1);
		chk({off, sden}, {4'h3, 4'hc});
		first_pair_enable = 1'b1;
		sig = 4'h0;
		step(1);
		chk(req & 4'h3, 4'h3);
		rst_n = 1'b0;
		step(2);
		chk({off, eq[0], gn[3]}, {4'hf, 4'h4, 4'h4});
		rst_n = 1'b1;
		step(1);
		chk({req, slp, sden, off}, {4'hf, 4'hf, 4'hf, 4'h0});
		chk({eq[1], gn[2]}, 8'h88);
		step(1);
		chk({req, slp, off}, {4'h0, 4'hf, 4'h0});
		step(2);
		wrap_up();
	end
endmodule : tb_rpm_power_mgr
